/* core/epr_pkg.sv */
/*
 * Package for the expansion port register block: register indices, mode
 * encodings and the carrier structs shared by the block and its users.
 * Assumes a 32-bit Avalon-MM slave with word addressing by byte address.
 */
package epr_pkg;
    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_PORT_A_DATA = 8'h00;
    localparam logic [7:0] IDX_PORT_B_DATA = 8'h01;
    localparam logic [7:0] IDX_PORT_A_DIRECTION = 8'h02;
    localparam logic [7:0] IDX_PORT_B_DIRECTION = 8'h03;
    localparam logic [7:0] IDX_PORT_E_DATA = 8'h08;
    localparam logic [7:0] IDX_PORT_E_DIRECTION = 8'h09;
    localparam logic [7:0] IDX_PORT_E_ASSIGNMENT = 8'h0A;
    localparam logic [7:0] IDX_PULLUP_CONTROL = 8'h0C;
    // first indices removed in special peripheral mode
    localparam logic [7:0] IDX_EXP_BLOCK_END = 8'h10;
    localparam int ADDR_W = 10;
    localparam int IDX_LSB = 2;

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int PEA_DBE = 7;
    localparam int PEA_TEST = 6;
    localparam int PEA_PIPE = 5;
    localparam int PEA_NO_BUS_CLOCK_OUTPUT = 4;
    localparam int PEA_LOW_BYTE_STROBE = 3;
    localparam int PEA_RDW = 2;
    localparam int PEA_CAL = 1;
    localparam int PEA_DBE_INV = 0;
    localparam int PUC_PORT_E = 4;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] PE_IRQ_MASK = 8'h03;
    // pull-up candidates: data bus enable, strobe, read/write, interrupts
    localparam logic [7:0] PE_PULL_MASK = 8'h8F;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        EPR_SC_NORMAL = 3'h0,
        EPR_SC_SPECIAL = 3'h1,
        EPR_EXP_NARROW = 3'h3,
        EPR_EXP_WIDE = 3'h2,
        EPR_EXP_SPECIAL = 3'h6,
        EPR_PERIPH = 3'h7,
        EPR_PERIPH_SPECIAL = 3'h5
    } epr_mode_e;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } epr_pins_s;

    typedef struct packed {
        logic [7:0] pa;
        logic [7:0] pb;
        logic [7:0] dda;
        logic [7:0] ddb;
        logic [7:0] pe;
        logic [7:0] dde;
        logic [7:0] port_e_assignment;
        logic [7:0] pucr;
        logic [31:0] rdata;
        logic rvalid;
        logic ext;
    } epr_state_s;
endpackage

/* core/epr_port_regs.sv */
/*
 * Port A, B and E register file and pin multiplexing for an 8-bit
 * microcontroller expansion bus. Assumes mode and emulation bits come
 * from logic on CLK_SYS and port pins arrive unsynchronised.
 */
`timescale 1ns/1ps
// How it works
// - special peripheral mode hides the first 16 expansion registers from the map
// - expanded modes use ports A, B for bus and send their registers outside
// - expanded mode with emulation sends port E data and direction registers outside
// - port A carries high address/data, plus low data in narrow mode
// - port B carries low address/data, only low address in narrow mode
// - ports A, B are plain I/O with direction bits when not bus
// - direction bit 0 makes an input, 1 makes an output
// - peripheral mode also hides the port A and B registers
// - each port E pin from 2 to 7 has its own fixed set of alternate functions
// - assignment register picks port E function, else direction register rules
// - one bit enables pull-ups on chosen port E pins that are inputs
// - port E data absent in peripheral mode and emulated expanded modes
// - mapped data registers are readable and writable at any time
// - the two interrupt pins never drive and always read back
// - an alternate port E function overrides the direction bit
module epr_port_regs
    import epr_pkg::*;
(
    input wire logic CLK_SYS, // system clock 250 MHz
    input wire logic RESET, // synchronous reset, active high
    input wire epr_mode_e MODE, // operating mode
    input wire logic EMULATE_PORT_E, // port E emulation enable
    input wire logic [epr_pkg::ADDR_W-1:0] AVS_ADDRESS, // byte address
    input wire logic AVS_READ, // read strobe
    input wire logic AVS_WRITE, // write strobe
    input wire logic [3:0] AVS_BYTEENABLE, // byte enables
    input wire logic [31:0] AVS_WRITEDATA, // write data
    output logic [31:0] AVS_READDATA, // read data
    output logic AVS_WAITREQUEST, // stall
    output logic [1:0] AVS_RESPONSE, // 00 okay, 11 decode error
    output logic EXT_ACCESS, // last access was routed externally
    input wire logic [15:0] BUS_ADDR, // external bus address
    input wire logic [15:0] BUS_WDATA, // external bus write data
    input wire logic BUS_ADDR_PHASE, // 1 address phase, 0 data phase
    input wire logic BUS_DRIVE_DATA, // data phase drives pins
    output logic [15:0] BUS_RDATA, // data read from the pins
    input wire logic [7:0] BUS_CTRL, // alternate port E outputs
    input wire logic [7:0] PA_IN, // port A pin level
    output logic [7:0] PA_OUT, // port A pin drive
    output logic [7:0] PA_OE, // port A output enable
    input wire logic [7:0] PB_IN, // port B pin level
    output logic [7:0] PB_OUT, // port B pin drive
    output logic [7:0] PB_OE, // port B output enable
    input wire logic [7:0] PE_IN, // port E pin level
    output logic [7:0] PE_OUT, // port E pin drive
    output logic [7:0] PE_OE, // port E output enable
    output logic [7:0] PE_PULLUP // port E pull-up enable
);
    // ------------------------------------------------------------------
    // state and pin synchronisers
    // ------------------------------------------------------------------
    epr_state_s st_ff, nxt_st;
    logic [23:0] pin_s1_ff, pin_s2_ff;
    logic [7:0] pa_in, pb_in, pe_in;
    logic [7:0] idx;
    logic expanded, periph, ab_off, e_off, req, hit, word_ok;

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
        end else begin
            pin_s1_ff <= {PA_IN, PB_IN, PE_IN};
            pin_s2_ff <= pin_s1_ff;
        end
    end
    assign {pa_in, pb_in, pe_in} = pin_s2_ff;

    // ------------------------------------------------------------------
    // map decode
    // ------------------------------------------------------------------
    assign idx = AVS_ADDRESS[ADDR_W-1:IDX_LSB];
    assign expanded = (MODE == EPR_EXP_NARROW) || (MODE == EPR_EXP_WIDE)
        || (MODE == EPR_EXP_SPECIAL);
    assign periph = (MODE == EPR_PERIPH) || (MODE == EPR_PERIPH_SPECIAL);
    // ports a and b leave the map
    assign ab_off = expanded || periph;
    // port e leaves the map with emulation in expanded modes, or in peripheral
    assign e_off = periph || (expanded && EMULATE_PORT_E);
    assign req = AVS_READ || AVS_WRITE;
    assign word_ok = (AVS_ADDRESS[IDX_LSB-1:0] == 2'b00);

    always_comb begin
        hit = 1'b0;
        case (idx)
            IDX_PORT_A_DATA, IDX_PORT_B_DATA,
            IDX_PORT_A_DIRECTION, IDX_PORT_B_DIRECTION: hit = !ab_off;
            IDX_PORT_E_DATA, IDX_PORT_E_DIRECTION: hit = !e_off;
            IDX_PORT_E_ASSIGNMENT, IDX_PULLUP_CONTROL: hit = !periph;
            default: hit = 1'b0;
        endcase
        if (MODE == EPR_PERIPH_SPECIAL && idx < IDX_EXP_BLOCK_END) begin
            hit = 1'b0;
        end
        if (!word_ok) begin
            hit = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register file: one-cycle wait then answer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rvalid = req && !st_ff.rvalid;
        if (req && !st_ff.rvalid) begin
            nxt_st.ext = !hit;
            nxt_st.rdata = RD_ZERO;
            if (hit && AVS_READ) begin
                case (idx)
                    IDX_PORT_A_DATA: nxt_st.rdata[7:0] =
                        (st_ff.pa & st_ff.dda) | (pa_in & ~st_ff.dda);
                    IDX_PORT_B_DATA: nxt_st.rdata[7:0] =
                        (st_ff.pb & st_ff.ddb) | (pb_in & ~st_ff.ddb);
                    IDX_PORT_A_DIRECTION: nxt_st.rdata[7:0] = st_ff.dda;
                    IDX_PORT_B_DIRECTION: nxt_st.rdata[7:0] = st_ff.ddb;
                    // interrupt pins always read the pin level
                    IDX_PORT_E_DATA: nxt_st.rdata[7:0] =
                        (st_ff.pe & PE_OE) | (pe_in & ~PE_OE);
                    IDX_PORT_E_DIRECTION: nxt_st.rdata[7:0] = st_ff.dde;
                    IDX_PORT_E_ASSIGNMENT: nxt_st.rdata[7:0] = st_ff.port_e_assignment;
                    IDX_PULLUP_CONTROL: nxt_st.rdata[7:0] = st_ff.pucr;
                    default: nxt_st.rdata = RD_ZERO;
                endcase
            end
            if (hit && AVS_WRITE && AVS_BYTEENABLE[0]) begin
                case (idx)
                    IDX_PORT_A_DATA: nxt_st.pa = AVS_WRITEDATA[7:0];
                    IDX_PORT_B_DATA: nxt_st.pb = AVS_WRITEDATA[7:0];
                    IDX_PORT_A_DIRECTION: nxt_st.dda = AVS_WRITEDATA[7:0];
                    IDX_PORT_B_DIRECTION: nxt_st.ddb = AVS_WRITEDATA[7:0];
                    IDX_PORT_E_DATA: nxt_st.pe = AVS_WRITEDATA[7:0];
                    IDX_PORT_E_DIRECTION: nxt_st.dde = AVS_WRITEDATA[7:0];
                    IDX_PORT_E_ASSIGNMENT: nxt_st.port_e_assignment = AVS_WRITEDATA[7:0];
                    IDX_PULLUP_CONTROL: nxt_st.pucr = AVS_WRITEDATA[7:0];
                    default: nxt_st.pa = st_ff.pa;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign AVS_WAITREQUEST = req && !st_ff.rvalid;
    assign AVS_READDATA = st_ff.rdata;
    assign AVS_RESPONSE = st_ff.ext ? 2'b11 : 2'b00;
    assign EXT_ACCESS = st_ff.ext;

    // ------------------------------------------------------------------
    // ports a and b pin drive
    // ------------------------------------------------------------------
    logic narrow;
    assign narrow = (MODE == EPR_EXP_NARROW);
    always_comb begin
        if (ab_off) begin
            // high address, high data, low data when narrow
            PA_OUT = BUS_ADDR_PHASE ? BUS_ADDR[15:8]
                : (narrow ? BUS_WDATA[7:0] : BUS_WDATA[15:8]);
            PA_OE = (BUS_ADDR_PHASE || BUS_DRIVE_DATA) ? 8'hFF : 8'h00;
            // low address, low data only when wide
            PB_OUT = (BUS_ADDR_PHASE || narrow) ? BUS_ADDR[7:0]
                : BUS_WDATA[7:0];
            PB_OE = (BUS_ADDR_PHASE || BUS_DRIVE_DATA || narrow)
                ? 8'hFF : 8'h00;
        end else begin
            PA_OUT = st_ff.pa;
            PA_OE = st_ff.dda;
            PB_OUT = st_ff.pb;
            PB_OE = st_ff.ddb;
        end
    end
    assign BUS_RDATA = narrow ? {pa_in, pa_in} : {pa_in, pb_in};

    // ------------------------------------------------------------------
    // port e function select
    // ------------------------------------------------------------------
    logic [7:0] alt;
    always_comb begin
        alt = RST_ZERO;
        alt[7] = (expanded && !st_ff.port_e_assignment[PEA_DBE])
            || st_ff.port_e_assignment[PEA_CAL];
        alt[6] = st_ff.port_e_assignment[PEA_PIPE] || st_ff.port_e_assignment[PEA_TEST];
        alt[5] = st_ff.port_e_assignment[PEA_PIPE];
        alt[4] = !st_ff.port_e_assignment[PEA_NO_BUS_CLOCK_OUTPUT];
        alt[3] = st_ff.port_e_assignment[PEA_LOW_BYTE_STROBE] && expanded && !narrow;
        alt[2] = st_ff.port_e_assignment[PEA_RDW] && expanded;
    end
    // interrupt pins are masked off as outputs
    assign PE_OE = ((alt | (st_ff.dde & ~alt)) & ~PE_IRQ_MASK)
        & ~(alt & ~BUS_CTRL & RST_ZERO);
    assign PE_OUT = (alt & BUS_CTRL) | (~alt & st_ff.pe);
    // one bit, chosen pins, inputs only
    assign PE_PULLUP = {8{st_ff.pucr[PUC_PORT_E]}} & PE_PULL_MASK & ~PE_OE;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_irq_never_out: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (PE_OE & PE_IRQ_MASK) == RST_ZERO)
        else $error("interrupt pin driven");
    a_ab_gpio_dir: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !ab_off |-> (PA_OE == st_ff.dda && PB_OE == st_ff.ddb))
        else $error("port a/b enable differs from direction");
    a_ab_hidden: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (AVS_READ && ab_off && idx == IDX_PORT_A_DATA && word_ok
        && !st_ff.rvalid) |=> AVS_RESPONSE == 2'b11)
        else $error("port a answered while hidden");
    a_e_hidden: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (req && e_off && idx == IDX_PORT_E_DATA && !st_ff.rvalid)
        |=> EXT_ACCESS)
        else $error("port e answered while hidden");
    a_sp_block: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (req && MODE == EPR_PERIPH_SPECIAL && idx < IDX_EXP_BLOCK_END
        && !st_ff.rvalid) |=> EXT_ACCESS)
        else $error("expansion block answered");
    a_write_lands: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (AVS_WRITE && !ab_off && word_ok && idx == IDX_PORT_A_DIRECTION
        && AVS_BYTEENABLE[0] && !st_ff.rvalid)
        |=> st_ff.dda == $past(AVS_WRITEDATA[7:0]))
        else $error("direction write lost");
    a_pull_inputs: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (PE_PULLUP & PE_OE) == RST_ZERO)
        else $error("pull-up on output");
    a_narrow_pb: assert property (@(posedge CLK_SYS) disable iff (RESET)
        narrow |-> (PB_OUT == BUS_ADDR[7:0] && PB_OE == 8'hFF))
        else $error("port b not address in narrow mode");
    a_wait_one: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (req && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST)
        else $error("wait longer than one cycle");

    // ------------------------------------------------------------------
    // handshake sequences
    // ------------------------------------------------------------------
    // a fresh request: strobe up with no answer pending
    sequence s_fresh_req;
        req && !st_ff.rvalid;
    endsequence

    // the answer one edge later: stall dropped, answer registered
    sequence s_answer;
        !AVS_WAITREQUEST && st_ff.rvalid;
    endsequence

    a_bus_answer: assert property (@(posedge CLK_SYS) disable iff (RESET)
        s_fresh_req |=> s_answer)
        else $error("no answer one cycle after request");

    a_miss_ext: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (s_fresh_req and !hit) |=> (EXT_ACCESS && AVS_RESPONSE == 2'b11))
        else $error("unmapped access not sent outside");

    a_hit_local: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (s_fresh_req and hit) |=> (!EXT_ACCESS && AVS_RESPONSE == 2'b00))
        else $error("mapped access sent outside");

    // upper read bits stay zero so software may read the whole word
    a_read_upper: assert property (@(posedge CLK_SYS) disable iff (RESET)
        st_ff.rvalid |-> AVS_READDATA[31:8] == 24'h00_0000)
        else $error("read data upper bits set");

    a_pa_addr: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (ab_off && BUS_ADDR_PHASE)
        |-> (PA_OUT == BUS_ADDR[15:8] && PA_OE == 8'hFF))
        else $error("port a not high address");

    a_narrow_pa: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (narrow && !BUS_ADDR_PHASE) |-> PA_OUT == BUS_WDATA[7:0])
        else $error("port a not low data in narrow mode");

    a_wide_pb: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (ab_off && !narrow && !BUS_ADDR_PHASE && BUS_DRIVE_DATA)
        |-> PB_OUT == BUS_WDATA[7:0])
        else $error("port b not low data in wide mode");

    a_ab_gpio_out: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !ab_off |-> (PA_OUT == st_ff.pa && PB_OUT == st_ff.pb))
        else $error("port a/b drive differs from latch");

    // bus-control pins drive regardless of the direction register
    a_e_alt_drive: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (alt & ~PE_IRQ_MASK & PE_OE) == (alt & ~PE_IRQ_MASK))
        else $error("alternate pin not driven");

    a_e_gpio_dir: assert property (@(posedge CLK_SYS) disable iff (RESET)
        ((PE_OE ^ st_ff.dde) & ~alt & ~PE_IRQ_MASK) == RST_ZERO)
        else $error("port e enable differs from direction");

    a_e_alt_value: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (alt & (PE_OUT ^ BUS_CTRL)) == RST_ZERO)
        else $error("alternate pin value wrong");

    a_pull_off: assert property (@(posedge CLK_SYS) disable iff (RESET)
        !st_ff.pucr[PUC_PORT_E] |-> PE_PULLUP == RST_ZERO)
        else $error("pull-up without enable");

    a_pull_pins: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (PE_PULLUP & ~PE_PULL_MASK) == RST_ZERO)
        else $error("pull-up on pin without one");

    a_periph_ab: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (s_fresh_req and (periph && idx == IDX_PORT_B_DIRECTION))
        |=> EXT_ACCESS)
        else $error("port b direction answered in peripheral mode");

    a_e_present: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (s_fresh_req and (!periph && !expanded && word_ok
        && idx == IDX_PORT_E_DATA)) |=> !EXT_ACCESS)
        else $error("port e data missing in single chip");

    a_emu_dir: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (s_fresh_req and (expanded && EMULATE_PORT_E
        && idx == IDX_PORT_E_DIRECTION)) |=> EXT_ACCESS)
        else $error("port e direction answered under emulation");

    // a hidden port a write must not reach the on-chip latch
    a_hidden_write: assert property (@(posedge CLK_SYS) disable iff (RESET)
        (s_fresh_req and (AVS_WRITE && ab_off))
        |=> st_ff.pa == $past(st_ff.pa))
        else $error("hidden write reached port a latch");
endmodule // epr_port_regs

/* test/epr_far_side.sv */
/*
 * Far side of the expansion pins: port replacement unit and bus devices.
 * Assumes the block hands pin drive and enable as epr_pins_s carriers.
 */
`timescale 1ns/1ps
module epr_far_side
    import epr_pkg::*;
#(
    parameter logic [7:0] PAT_A = 8'h5A,
    parameter logic [7:0] PAT_B = 8'hC3,
    parameter logic [7:0] PAT_E = 8'h69
)(
    input wire epr_pins_s PA_DRV, // port A drive from block
    input wire epr_pins_s PB_DRV, // port B drive from block
    input wire epr_pins_s PE_DRV, // port E drive from block
    output logic [7:0] PA_LVL, // port A wire level
    output logic [7:0] PB_LVL, // port B wire level
    output logic [7:0] PE_LVL // port E wire level
);
    // ------------------------------------------------------------
    // wire resolution
    // ------------------------------------------------------------
    // released pins show the unit's own levels, never the last drive
    assign PA_LVL = (PA_DRV.out & PA_DRV.oe) | (PAT_A & ~PA_DRV.oe);
    assign PB_LVL = (PB_DRV.out & PB_DRV.oe) | (PAT_B & ~PB_DRV.oe);
    assign PE_LVL = (PE_DRV.out & PE_DRV.oe) | (PAT_E & ~PE_DRV.oe);
endmodule // epr_far_side

/* test/expansion_port_register_map_bench.sv */
/*
 * Self-checking bench for the expansion port register block.
 * Assumes epr_port_regs and the far side model epr_far_side.
 */
`timescale 1ns/1ps
module expansion_port_register_map_bench;
    import epr_pkg::*;
    typedef struct packed {
        epr_mode_e mode;
        logic emu;
        logic [7:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
        logic ok;
    } epr_row_s;
    logic clk = 1'b0, rst = 1'b1, emu = 1'b0, rd_s = 1'b0, wr_s = 1'b0;
    epr_mode_e mode = EPR_SC_NORMAL;
    logic [9:0] adr = '0;
    logic [31:0] wdat = '0, rdat, r;
    logic [1:0] resp, s;
    logic wait_s, ext, b_aph = 1'b0, b_drv = 1'b0;
    logic [15:0] b_addr = '0, b_wdata = '0, b_rdata;
    logic [7:0] b_ctrl = '0, pa_in, pa_out, pa_oe, pb_in, pb_out, pb_oe;
    logic [7:0] pe_in, pe_out, pe_oe, pe_pu;
    int mismatches = 0, n_compared = 0, cycles = 0;
    epr_row_s rows [16] = '{
        '{EPR_SC_NORMAL, 1'b0, 8'h02, 8'hFF, 8'hFF, 1'b1},
        '{EPR_SC_NORMAL, 1'b0, 8'h00, 8'hA5, 8'hA5, 1'b1},
        '{EPR_SC_NORMAL, 1'b0, 8'h03, 8'h0F, 8'h0F, 1'b1},
        '{EPR_SC_NORMAL, 1'b0, 8'h01, 8'h3C, 8'hCC, 1'b1},
        '{EPR_SC_NORMAL, 1'b0, 8'h09, 8'hFC, 8'hFC, 1'b1},
        '{EPR_SC_NORMAL, 1'b0, 8'h08, 8'h96, 8'h95, 1'b1},
        '{EPR_SC_NORMAL, 1'b0, 8'h05, 8'h77, 8'h00, 1'b0},
        '{EPR_EXP_WIDE, 1'b0, 8'h00, 8'h11, 8'h00, 1'b0},
        '{EPR_EXP_WIDE, 1'b0, 8'h03, 8'h11, 8'h00, 1'b0},
        '{EPR_EXP_WIDE, 1'b0, 8'h09, 8'hFC, 8'hFC, 1'b1},
        '{EPR_EXP_WIDE, 1'b1, 8'h08, 8'h11, 8'h00, 1'b0},
        '{EPR_EXP_NARROW, 1'b0, 8'h01, 8'h11, 8'h00, 1'b0},
        '{EPR_PERIPH, 1'b0, 8'h02, 8'h11, 8'h00, 1'b0},
        '{EPR_PERIPH, 1'b0, 8'h08, 8'h11, 8'h00, 1'b0},
        '{EPR_PERIPH_SPECIAL, 1'b0, 8'h09, 8'h11, 8'h00, 1'b0},
        '{EPR_SC_SPECIAL, 1'b1, 8'h08, 8'h96, 8'h95, 1'b1}};

    always #2 clk = ~clk;

    epr_port_regs uut (.CLK_SYS(clk), .RESET(rst), .MODE(mode),
        .EMULATE_PORT_E(emu), .AVS_ADDRESS(adr), .AVS_READ(rd_s),
        .AVS_WRITE(wr_s), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wdat),
        .AVS_READDATA(rdat), .AVS_WAITREQUEST(wait_s), .AVS_RESPONSE(resp),
        .EXT_ACCESS(ext), .BUS_ADDR(b_addr), .BUS_WDATA(b_wdata),
        .BUS_ADDR_PHASE(b_aph), .BUS_DRIVE_DATA(b_drv), .BUS_RDATA(b_rdata),
        .BUS_CTRL(b_ctrl), .PA_IN(pa_in), .PA_OUT(pa_out), .PA_OE(pa_oe),
        .PB_IN(pb_in), .PB_OUT(pb_out), .PB_OE(pb_oe), .PE_IN(pe_in),
        .PE_OUT(pe_out), .PE_OE(pe_oe), .PE_PULLUP(pe_pu));
    epr_far_side far (.PA_DRV({pa_out, pa_oe}), .PB_DRV({pb_out, pb_oe}),
        .PE_DRV({pe_out, pe_oe}), .PA_LVL(pa_in), .PB_LVL(pb_in),
        .PE_LVL(pe_in));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic [7:0] idx, input logic wr,
        input logic [7:0] wd, output logic [31:0] rd, output logic [1:0] rs);
        @(posedge clk);
        adr <= {idx, 2'b00};
        rd_s <= ~wr;
        wr_s <= wr;
        wdat <= {24'h0, wd};
        @(posedge clk);
        while (wait_s !== 1'b0) @(posedge clk);
        rd = rdat;
        rs = resp;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
        // let the completing edge settle before pins are looked at
        @(negedge clk);
    endtask
    task automatic conclude;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        bus(8'h02, 1'b0, 8'h00, r, s);
        chk(r, 32'h0);
        chk(32'(pa_oe), 32'h0);
        $display("reset test done");
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            mode <= rows[i].mode;
            emu <= rows[i].emu;
            bus(rows[i].idx, 1'b1, rows[i].wd, r, s);
            chk(32'(s), rows[i].ok ? 32'h0 : 32'h3);
            bus(rows[i].idx, 1'b0, 8'h00, r, s);
            chk(r, 32'(rows[i].exp));
            chk(32'(ext), 32'(!rows[i].ok));
            $display("row %0d done", i);
        end
        @(posedge clk);
        mode <= EPR_SC_NORMAL;
        emu <= 1'b0;
        bus(8'h00, 1'b0, 8'h00, r, s);
        chk(r, 32'hA5);
        bus(8'h02, 1'b1, 8'h0F, r, s);
        chk(32'(pa_oe), 32'h0F);
        chk(32'(pa_out & 8'h0F), 32'h05);
        bus(8'h09, 1'b1, 8'hFF, r, s);
        chk(32'(pe_oe & 8'h03), 32'h0);
        bus(8'h08, 1'b0, 8'h00, r, s);
        chk(r & 32'h3, 32'h1);
        bus(8'h0C, 1'b1, 8'h10, r, s);
        bus(8'h09, 1'b1, 8'hFC, r, s);
        chk(32'(pe_pu), 32'h03);
        bus(8'h09, 1'b1, 8'h00, r, s);
        chk(32'(pe_pu), 32'h8F);
        $display("pin direction test done");
        @(posedge clk);
        mode <= EPR_EXP_WIDE;
        b_ctrl <= 8'h04;
        bus(8'h0A, 1'b1, 8'h04, r, s);
        bus(8'h09, 1'b1, 8'h08, r, s);
        chk(32'(pe_oe & 8'h0C), 32'h0C);
        chk(32'(pe_out & 8'h04), 32'h04);
        @(posedge clk);
        b_aph <= 1'b1;
        b_addr <= 16'h1234;
        @(negedge clk);
        chk({pa_out, pb_out, pa_oe, pb_oe}, 32'h1234FFFF);
        @(posedge clk);
        b_aph <= 1'b0;
        b_drv <= 1'b1;
        b_wdata <= 16'hBEEF;
        @(negedge clk);
        chk(32'({pa_out, pb_out}), 32'hBEEF);
        @(posedge clk);
        b_drv <= 1'b0;
        // pins pass a two-flop synchroniser before reaching the bus
        repeat (4) @(posedge clk);
        chk(32'(b_rdata), 32'h5AC3);
        mode <= EPR_EXP_NARROW;
        b_aph <= 1'b1;
        @(negedge clk);
        chk(32'({pa_out, pb_out}), 32'h1234);
        $display("bus pin test done");
        conclude();
    end
endmodule // expansion_port_register_map_bench
